// ==== rtl/tict_regs.vh ====
// Constants for the three channel interval timer: bus decode, setup word fields, codes.
// Included by the timer top and its channel module; holds definitions only.
`ifndef TICT_REGS_VH
`define TICT_REGS_VH

// ----------------------------------------------------------------
// Register select decode
// ----------------------------------------------------------------
`define TICT_SEL_CNT0 2'b00
`define TICT_SEL_CNT1 2'b01
`define TICT_SEL_CNT2 2'b10
`define TICT_SEL_SETUP 2'b11

// ----------------------------------------------------------------
// Setup word fields
// ----------------------------------------------------------------
`define TICT_PICK_MSB 7
`define TICT_PICK_LSB 6
`define TICT_ORDER_MSB 5
`define TICT_ORDER_LSB 4
`define TICT_MODE_MSB 3
`define TICT_MODE_LSB 1
`define TICT_FMT_BIT 0
`define TICT_PICK_ILLEGAL 2'b11

// ----------------------------------------------------------------
// Byte access codes
// ----------------------------------------------------------------
`define TICT_ACC_LATCH 2'b00
`define TICT_ACC_LSB 2'b01
`define TICT_ACC_MSB 2'b10
`define TICT_ACC_BOTH 2'b11

// ----------------------------------------------------------------
// Mode codes after decode
// ----------------------------------------------------------------
`define TICT_MODE0 3'h0
`define TICT_MODE1 3'h1
`define TICT_MODE2 3'h2
`define TICT_MODE3 3'h3
`define TICT_MODE4 3'h4
`define TICT_MODE5 3'h5

// ----------------------------------------------------------------
// Reset values (hardware leaves these undefined; chosen for determinism) and the BCD top count
// ----------------------------------------------------------------
`define TICT_RST_COUNT 16'h0000
`define TICT_RST_SETUP 8'h00
`define TICT_BCD_MAX 16'h9999

`endif

// ==== rtl/tict_channel.v ====
// One 16-bit presettable down counter with gate, output, six modes and binary/BCD count.
// Assumes CLK is much faster than the counter clock input; CNT_CLK and GATE are synchronous.
`timescale 1ns/1ps
`include "tict_regs.vh"

module tict_channel (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Counter pins
  input wire cnt_clk,
  input wire gate,
  output reg out_r,
  // Programming strobes from the bus side
  input wire setup_we,
  input wire [7:0] setup_word,
  input wire data_we,
  input wire data_rd,
  input wire [7:0] wdata,
  // Readback
  output reg [7:0] rdata_r
);

  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_WAIT = 2'd1;
  localparam [1:0] ST_RUN = 2'd2;

  reg [2:0] mode_r;
  reg [1:0] acc_r;
  reg bcd_r;
  reg [15:0] cnt_r;
  reg [15:0] init_r;
  reg [15:0] hold_r;
  reg latched_r;
  reg wr_msb_next_r;
  reg rd_msb_next_r;
  reg load_pend_r;
  reg armed_r;
  reg trig_r;
  reg [1:0] state_r;
  reg clk_d_r;
  reg gate_d_r;
  reg seen_rise_r;
  reg odd_first_r;

  wire clk_rise = cnt_clk & ~clk_d_r;
  wire clk_fall = ~cnt_clk & clk_d_r;
  wire gate_rise = gate & ~gate_d_r;
  wire [2:0] dec_mode = setup_word[`TICT_MODE_MSB -: 3];
  wire [1:0] dec_acc = setup_word[`TICT_ORDER_MSB:`TICT_ORDER_LSB];

  // ----------------------------------------------------------------
  // Count arithmetic
  // ----------------------------------------------------------------
  // Subtract 1..3 in binary or in four BCD decades; zero wraps to the top value.
  function [15:0] sub_n;
    input [15:0] v;
    input [1:0] n;
    input bcd;
    reg [15:0] r;
    begin
      r = v;
      if (!bcd) begin
        r = v - {14'h0000, n};
      end else begin
        // Fixed chain of single steps keeps the decade logic free of variable loops
        if (n != 2'd0) begin
          r = dec_bcd(r);
        end
        if (n[1]) begin
          r = dec_bcd(r);
        end
        if (n == 2'd3) begin
          r = dec_bcd(r);
        end
      end
      sub_n = r;
    end
  endfunction

  function [15:0] dec_bcd;
    input [15:0] v;
    reg [15:0] r;
    reg borrow;
    integer i;
    begin
      r = v;
      borrow = 1'b1;
      for (i = 0; i < 4; i = i + 1) begin
        if (borrow) begin
          if (r[4*i +: 4] == 4'h0) begin
            r[4*i +: 4] = 4'h9;
          end else begin
            r[4*i +: 4] = r[4*i +: 4] - 4'h1;
            borrow = 1'b0;
          end
        end
      end
      dec_bcd = r;
    end
  endfunction

  // Terminal count: the step from the current value lands on zero.
  wire [1:0] step = (mode_r == `TICT_MODE3) ? (odd_first_r ? (out_r ? 2'd1 : 2'd3) : 2'd2) :
                    2'd1;
  wire [15:0] cnt_nxt = sub_n(cnt_r, step, bcd_r);
  wire hits_zero = (cnt_nxt == 16'h0000);
  wire gate_ok = gate;
  wire [15:0] live = latched_r ? hold_r : cnt_r;

  // ----------------------------------------------------------------
  // Channel state
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      mode_r <= `TICT_MODE0;
      acc_r <= `TICT_ACC_BOTH;
      bcd_r <= 1'b0;
      cnt_r <= `TICT_RST_COUNT;
      init_r <= `TICT_RST_COUNT;
      hold_r <= `TICT_RST_COUNT;
      latched_r <= 1'b0;
      wr_msb_next_r <= 1'b0;
      rd_msb_next_r <= 1'b0;
      load_pend_r <= 1'b0;
      armed_r <= 1'b0;
      trig_r <= 1'b0;
      state_r <= ST_IDLE;
      clk_d_r <= 1'b0;
      // Idle gate level is high; a low value here would fake a rising edge after reset
      gate_d_r <= 1'b1;
      seen_rise_r <= 1'b0;
      odd_first_r <= 1'b0;
      out_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      clk_d_r <= cnt_clk;
      gate_d_r <= gate;
      if (gate_rise) begin
        trig_r <= 1'b1;
      end
      if (clk_rise && (load_pend_r || trig_r)) begin
        seen_rise_r <= 1'b1;
      end
      if (setup_we && dec_acc == `TICT_ACC_LATCH) begin
        if (!latched_r) begin
          hold_r <= cnt_r;
          latched_r <= 1'b1;
        end
      end else if (setup_we) begin
        mode_r <= (dec_mode[1]) ? {1'b0, dec_mode[1:0]} : dec_mode;
        acc_r <= dec_acc;
        bcd_r <= setup_word[`TICT_FMT_BIT];
        wr_msb_next_r <= 1'b0;
        rd_msb_next_r <= 1'b0;
        latched_r <= 1'b0;
        load_pend_r <= 1'b0;
        armed_r <= 1'b0;
        trig_r <= gate_rise;
        seen_rise_r <= 1'b0;
        state_r <= ST_IDLE;
        out_r <= (dec_mode == `TICT_MODE0) ? 1'b0 : 1'b1;
      end else if (data_we) begin
        if (acc_r == `TICT_ACC_MSB) begin
          init_r <= {wdata, 8'h00};
          load_pend_r <= 1'b1;
        end else if (acc_r == `TICT_ACC_LSB) begin
          init_r <= {8'h00, wdata};
          load_pend_r <= 1'b1;
        end else if (!wr_msb_next_r) begin
          init_r[7:0] <= wdata;
          wr_msb_next_r <= 1'b1;
          if (mode_r == `TICT_MODE0) begin
            state_r <= ST_IDLE;
          end
        end else begin
          init_r[15:8] <= wdata;
          wr_msb_next_r <= 1'b0;
          load_pend_r <= 1'b1;
        end
        seen_rise_r <= 1'b0;
        if (mode_r == `TICT_MODE0) begin
          out_r <= 1'b0;
        end
      end else begin
        if (data_rd) begin
          if (acc_r == `TICT_ACC_BOTH) begin
            rd_msb_next_r <= ~rd_msb_next_r;
            if (rd_msb_next_r) begin
              latched_r <= 1'b0;
            end
          end else begin
            latched_r <= 1'b0;
          end
        end
        // Counting happens on falling counter clock edges only.
        if (clk_fall) begin
          if (load_pend_r && seen_rise_r &&
              (mode_r == `TICT_MODE0 || mode_r == `TICT_MODE4 ||
               state_r == ST_IDLE)) begin
            // the count enters the counting element here, except in modes 1 and 5, which wait for the gate trigger
            load_pend_r <= 1'b0;
            seen_rise_r <= 1'b0;
            armed_r <= 1'b1;
            if (mode_r == `TICT_MODE1 || mode_r == `TICT_MODE5) begin
              state_r <= ST_WAIT;
            end else begin
              cnt_r <= init_r; // zero wraps to the full range
              odd_first_r <= init_r[0];
              state_r <= ST_RUN;
              if (mode_r == `TICT_MODE3 || mode_r == `TICT_MODE2) begin
                out_r <= 1'b1;
              end
            end
          end else if (armed_r && trig_r && seen_rise_r &&
                       (mode_r == `TICT_MODE1 || mode_r == `TICT_MODE5 ||
                        mode_r == `TICT_MODE2 || mode_r == `TICT_MODE3)) begin
            // gate rising edge reloads, acts after next clock
            // A gate edge in this very cycle must not be lost
            trig_r <= gate_rise;
            seen_rise_r <= 1'b0;
            cnt_r <= init_r;
            odd_first_r <= init_r[0];
            state_r <= ST_RUN;
            if (mode_r == `TICT_MODE1) begin
              out_r <= 1'b0;
            end else begin
              out_r <= 1'b1;
            end
          end else if (state_r == ST_RUN) begin
            case (mode_r)
              `TICT_MODE0: begin
                if (gate_ok) begin
                  cnt_r <= cnt_nxt;
                  if (hits_zero) begin
                    out_r <= 1'b1;
                  end
                end
              end
              `TICT_MODE1: begin
                cnt_r <= cnt_nxt;
                if (hits_zero) begin
                  out_r <= 1'b1;
                  state_r <= ST_WAIT;
                end
              end
              `TICT_MODE2: begin
                if (gate_ok) begin
                  if (!out_r) begin
                    out_r <= 1'b1;
                    cnt_r <= init_r;
                  end else begin
                    cnt_r <= cnt_nxt;
                    if (cnt_nxt == 16'h0001) begin
                      out_r <= 1'b0;
                    end
                  end
                end
              end
              `TICT_MODE3: begin
                if (gate_ok) begin
                  if (hits_zero || cnt_nxt == 16'hFFFF) begin
                    out_r <= ~out_r;
                    cnt_r <= init_r;
                  end else begin
                    cnt_r <= cnt_nxt;
                    odd_first_r <= 1'b0;
                  end
                  if (hits_zero) begin
                    odd_first_r <= init_r[0];
                  end
                end
              end
              `TICT_MODE4, `TICT_MODE5: begin
                if (!out_r) begin
                  out_r <= 1'b1;
                  state_r <= ST_WAIT;
                end else if (gate_ok || mode_r == `TICT_MODE5) begin
                  cnt_r <= cnt_nxt;
                  if (hits_zero) begin
                    out_r <= 1'b0;
                  end
                end
              end
              default: begin
                state_r <= ST_IDLE;
              end
            endcase
          end
        end
        // A low gate forces the output high at once in the divider modes.
        if (!gate && (mode_r == `TICT_MODE2 || mode_r == `TICT_MODE3) && !setup_we) begin
          out_r <= 1'b1;
        end
      end
      // byte order on read; two-byte reads must finish before a load
      if (acc_r == `TICT_ACC_MSB || (acc_r == `TICT_ACC_BOTH && rd_msb_next_r)) begin
        rdata_r <= live[15:8];
      end else begin
        rdata_r <= live[7:0];
      end
    end
  end

endmodule // tict_channel

// ==== rtl/tict_timer.v ====
// Notes on behaviour
// - Both select lines high address the setup word; those writes configure, never load.
// - The setup word is write-only; reading its address returns nothing.
// - Three identical independent 16-bit down counters with own clock, gate, output.
// - Setup word: counter pick 7:6, byte order 5:4, mode 3:1, format bit 0.
// - Order 10 high byte, 01 low byte, 11 low then high, loads and reads.
// - Byte order zero is a latch command, not a mode change.
// - Mode codes 000,001,X10,X11,100,101 give modes 0 to 5.
// - Format bit 0 counts binary, 1 counts four BCD decades.
// - A count takes effect after full bytes, then counter clock rise and fall.
// - Mode 0 output low from setup, high at terminal count; counting continues.
// - Mode 0 rewrite: first byte halts counting, second byte starts new count.
// - Mode 1 output low after gate rise, high at terminal count, retriggerable.
// - Mode 2 divides by N, output low one clock per period.
// - Mode 2 low gate forces output high; rise restarts; high until loaded.
// - Mode 3 even count steps by two, toggling and reloading at terminal count.
// - Mode 3 odd count: first step 1 high, 3 low; unequal halves.
// - Mode 4 output high after setup; one low clock at terminal count.
// - Mode 4 rewritten count taken next clock; low gate suspends counting.
// - Mode 5 gate rise starts full count, low pulse at terminal count.
// - Modes 1 and 5 only the gate rising edge matters.
// - Modes 2,3 low gate stops and sets output; modes 0,4 gate enables.
// - A zero count gives the maximum span, 65536 binary or 10000 BCD.
// - Latch holds the present value for reads; counting and mode untouched; a counter clock fall in the latch command cycle is not counted.
//
// Top of the interval timer: 8-bit I/O port decode and three counter channels.
// Assumes bus strobes are synchronous to CLK and held one or more cycles per access.
`timescale 1ns/1ps
`include "tict_regs.vh"

module tict_timer #(
  parameter integer NUM_CH = 3
) (
  // Clock and reset
  input wire CLK,
  input wire SYS_RST,
  // Host I/O bus
  input wire CS_N,
  input wire RD_N,
  input wire WR_N,
  input wire REG_SELECT_LO,
  input wire REG_SELECT_HI,
  input wire [7:0] DATA_IN,
  output reg [7:0] DATA_OUT,
  output reg DATA_OE_N,
  // Counter pins
  input wire [2:0] CNT_CLK,
  input wire [2:0] GATE,
  output wire [2:0] CNT_OUT
);

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  wire [1:0] sel = {REG_SELECT_HI, REG_SELECT_LO};
  wire wr_act = ~CS_N & ~WR_N & RD_N;
  wire rd_act = ~CS_N & ~RD_N & WR_N;
  reg wr_d_r;
  reg rd_d_r;
  // Strobes act once per access, on the trailing edge for reads so the byte stays stable.
  wire wr_pulse = wr_act & ~wr_d_r;
  wire rd_done = rd_d_r & ~rd_act;
  reg [1:0] rd_sel_r;

  always @(posedge CLK) begin
    if (SYS_RST) begin
      wr_d_r <= 1'b0;
      rd_d_r <= 1'b0;
      rd_sel_r <= `TICT_SEL_CNT0;
    end else begin
      wr_d_r <= wr_act;
      rd_d_r <= rd_act;
      if (rd_act) begin
        rd_sel_r <= sel;
      end
    end
  end

  wire setup_hit = wr_pulse && sel == `TICT_SEL_SETUP;
  wire [1:0] pick = DATA_IN[`TICT_PICK_MSB:`TICT_PICK_LSB];

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  wire [7:0] ch_rdata [0:2];
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g = g + 1) begin : g_ch
      tict_channel u_ch (
        .clk(CLK),
        .rst(SYS_RST),
        .cnt_clk(CNT_CLK[g]),
        .gate(GATE[g]),
        .out_r(CNT_OUT[g]),
        .setup_we(setup_hit && pick == g[1:0] && pick != `TICT_PICK_ILLEGAL),
        .setup_word(DATA_IN),
        .data_we(wr_pulse && sel == g[1:0]),
        .data_rd(rd_done && rd_sel_r == g[1:0]),
        .wdata(DATA_IN),
        .rdata_r(ch_rdata[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // The setup address floats the bus: no path returns the stored word.
  always @(posedge CLK) begin
    if (SYS_RST) begin
      DATA_OUT <= 8'h00;
      DATA_OE_N <= 1'b1;
    end else begin
      DATA_OE_N <= ~(rd_act && sel != `TICT_SEL_SETUP);
      case (sel)
        `TICT_SEL_CNT0: DATA_OUT <= ch_rdata[0];
        `TICT_SEL_CNT1: DATA_OUT <= ch_rdata[1];
        `TICT_SEL_CNT2: DATA_OUT <= ch_rdata[2];
        default: DATA_OUT <= 8'h00;
      endcase
    end
  end

endmodule // tict_timer

// ==== testbench/tict_host_model.sv ====
// Host side of the timer I/O port: strobed byte writes and reads.
// Shares CLK with the timer; the bench calls its tasks.
`timescale 1ns/1ps
module tict_host_model (
  // Clock
  input wire CLK,
  // I/O bus
  output reg CS_N,
  output reg RD_N,
  output reg WR_N,
  output reg [1:0] SEL,
  output reg [7:0] DATA_IN,
  input wire [7:0] DATA_OUT,
  input wire DATA_OE_N
);
  initial begin
    CS_N = 1'b1;
    RD_N = 1'b1;
    WR_N = 1'b1;
    SEL = 2'h0;
    DATA_IN = 8'h00;
  end
  // Strobe held two edges, two idle edges before the next access
  task wr(input [1:0] s, input [7:0] d);
    begin
      @(posedge CLK);
      CS_N <= 1'b0;
      WR_N <= 1'b0;
      SEL <= s;
      DATA_IN <= d;
      repeat (2) @(posedge CLK);
      CS_N <= 1'b1;
      WR_N <= 1'b1;
      // Released bus must not keep showing the written byte
      DATA_IN <= ~d;
      repeat (2) @(posedge CLK);
    end
  endtask
  // Data may lag a cycle behind the enable, so sample on the third edge
  task rd(input [1:0] s, output [7:0] d, output oe_n);
    begin
      @(posedge CLK);
      CS_N <= 1'b0;
      RD_N <= 1'b0;
      SEL <= s;
      repeat (3) @(posedge CLK);
      d = DATA_OUT;
      oe_n = DATA_OE_N;
      CS_N <= 1'b1;
      RD_N <= 1'b1;
      repeat (2) @(posedge CLK);
    end
  endtask
endmodule // tict_host_model

// ==== testbench/tict_timer_sva.sv ====
// Checker for the timer ports: bus answers, reset state, output shapes.
// Sees the top ports only; the mode of each channel is decoded from bus writes.
`timescale 1ns/1ps
module tict_timer_sva (
  // Clock and reset
  input wire CLK,
  input wire SYS_RST,
  // Host I/O bus
  input wire CS_N,
  input wire RD_N,
  input wire WR_N,
  input wire REG_SELECT_LO,
  input wire REG_SELECT_HI,
  input wire [7:0] DATA_IN,
  input wire DATA_OE_N,
  // Counter pins
  input wire [2:0] GATE,
  input wire [2:0] CNT_OUT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  reg wr_q;
  reg [2:0] mode_r [0:2];
  wire sel3 = REG_SELECT_LO && REG_SELECT_HI;
  wire rd_on = !CS_N && !RD_N;
  wire [2:0] md = DATA_IN[2] ? {1'b0, DATA_IN[2:1]} : DATA_IN[3:1];
  // Write acts once per low period, so only its first cycle is an event
  wire set_ev = !CS_N && !WR_N && RD_N && wr_q && sel3 && DATA_IN[7:6] != 2'h3 &&
    DATA_IN[5:4] != 2'h0;
  always @(posedge CLK) begin
    wr_q <= WR_N || CS_N;
    if (SYS_RST) begin
      mode_r[0] <= 3'h0;
      mode_r[1] <= 3'h0;
      mode_r[2] <= 3'h0;
    end else if (set_ev) begin
      mode_r[DATA_IN[7:6]] <= md;
    end
  end
  sequence s_rd2;
    (rd_on && !sel3) [*2];
  endsequence
  AST_SETUP_NO_READ: assert property (rd_on && sel3 |=> DATA_OE_N)
    else $error("setup word address drove the data bus");
  AST_READ_DRIVE: assert property (s_rd2 |-> !DATA_OE_N)
    else $error("counter read did not drive the data bus");
  AST_IDLE_FLOAT: assert property (!rd_on [*2] |-> DATA_OE_N)
    else $error("data bus driven without a read");
  AST_RESET: assert property (disable iff (1'b0) SYS_RST |=>
    DATA_OE_N && CNT_OUT == 3'h0)
    else $error("reset state wrong");
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_ch
      wire ev = set_ev && DATA_IN[7:6] == i;
      wire m23 = mode_r[i] == 3'h2 || mode_r[i] == 3'h3;
      wire m245 = mode_r[i] == 3'h2 || mode_r[i] == 3'h4 || mode_r[i] == 3'h5;
      AST_MODE0_LOW: assert property (ev && md == 3'h0 |-> ##3 !CNT_OUT[i] [*4])
        else $error("mode 0 output not low after setup");
      AST_SET_HIGH: assert property (ev && (md == 3'h2 || md == 3'h4) |->
        ##3 CNT_OUT[i] [*4])
        else $error("mode 2 or 4 output not high after setup");
      AST_GATE_HIGH: assert property (m23 && !GATE[i] [*4] |-> CNT_OUT[i])
        else $error("low gate did not force output high");
      AST_PULSE_ONE: assert property ($fell(CNT_OUT[i]) && m245
        |-> ##[1:16] CNT_OUT[i])
        else $error("low pulse longer than one counter clock");
    end
  endgenerate
endmodule // tict_timer_sva
bind tict_timer tict_timer_sva tict_timer_sva_i (.CLK(CLK), .SYS_RST(SYS_RST), .CS_N(CS_N),
  .RD_N(RD_N), .WR_N(WR_N), .REG_SELECT_LO(REG_SELECT_LO), .REG_SELECT_HI(REG_SELECT_HI),
  .DATA_IN(DATA_IN), .DATA_OE_N(DATA_OE_N), .GATE(GATE), .CNT_OUT(CNT_OUT));

// ==== testbench/tict_timer_test.sv ====
// Self-checking bench for the timer: modes, formats, byte orders, refusals.
// Counter clocks are slow pulses made here; the host model drives the bus.
`timescale 1ns/1ps
module tict_timer_test;
  localparam integer HP = 5;
  reg CLK = 1'b0;
  reg SYS_RST = 1'b1;
  reg [2:0] CNT_CLK = 3'h0;
  reg [2:0] GATE = 3'h7;
  wire CS_N, RD_N, WR_N, DATA_OE_N;
  wire [1:0] sel;
  wire [7:0] DATA_IN, DATA_OUT;
  wire [2:0] CNT_OUT;
  reg [2:0] out_q = 3'h0;
  reg [15:0] falls [0:2];
  reg [15:0] v, w;
  reg [31:0] r;
  reg [7:0] b;
  reg oe;
  integer miscompares = 0;
  integer n_tests = 0;
  integer i, k, n;
  always #4 CLK = ~CLK;
  tict_timer tict_timer_i (.CLK(CLK), .SYS_RST(SYS_RST), .CS_N(CS_N), .RD_N(RD_N),
    .WR_N(WR_N), .REG_SELECT_LO(sel[0]), .REG_SELECT_HI(sel[1]), .DATA_IN(DATA_IN),
    .DATA_OUT(DATA_OUT), .DATA_OE_N(DATA_OE_N), .CNT_CLK(CNT_CLK), .GATE(GATE),
    .CNT_OUT(CNT_OUT));
  tict_host_model tict_host_model_i (.CLK(CLK), .CS_N(CS_N), .RD_N(RD_N), .WR_N(WR_N),
    .SEL(sel), .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .DATA_OE_N(DATA_OE_N));
  always @(posedge CLK) begin : cnt_falls
    integer j;
    out_q <= CNT_OUT;
    for (j = 0; j < 3; j = j + 1) begin
      if (SYS_RST)
        falls[j] <= 16'h0000;
      else if (out_q[j] && !CNT_OUT[j])
        falls[j] <= falls[j] + 16'h0001;
    end
  end
  task chk16(input [15:0] got, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task chk1(input got, input exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task complete_run;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task pulse(input integer ch, input integer cnt);
    integer p;
    begin
      for (p = 0; p < cnt; p = p + 1) begin
        @(posedge CLK);
        CNT_CLK[ch] <= 1'b1;
        repeat (HP) @(posedge CLK);
        CNT_CLK[ch] <= 1'b0;
        repeat (HP) @(posedge CLK);
      end
    end
  endtask
  // Mode is always programmed before outputs are judged; some checks come before the count is loaded
  task setw(input [1:0] c, input [1:0] a, input [2:0] m, input f);
    tict_host_model_i.wr(2'h3, {c, a, m, f});
  endtask
  task load16(input [1:0] c, input [15:0] d);
    begin
      tict_host_model_i.wr(c, d[7:0]);
      tict_host_model_i.wr(c, d[15:8]);
    end
  endtask
  // Both bytes are read before any further load of the channel
  task rd16(input [1:0] c, output [15:0] d);
    begin
      tict_host_model_i.wr(2'h3, {c, 6'h00});
      tict_host_model_i.rd(c, d[7:0], oe);
      tict_host_model_i.rd(c, d[15:8], oe);
    end
  endtask
  function [15:0] after(input [15:0] v0, input integer st, input f);
    integer d;
    begin
      after = v0 - st[15:0];
      if (f) begin
        d = v0[15:12] * 1000 + v0[11:8] * 100 + v0[7:4] * 10 + v0[3:0];
        d = (d - st + 10000) % 10000;
        after = {4'(d / 1000), 4'((d / 100) % 10), 4'((d / 10) % 10), 4'(d % 10)};
      end
    end
  endfunction
  initial begin
    r = $urandom(22735);
    repeat (12) @(posedge CLK);
    SYS_RST <= 1'b0;
    @(posedge CLK);
    n = 3 + $urandom % 14;
    setw(2'h0, 2'h3, 3'h0, 1'b0);
    chk1(CNT_OUT[0], 1'b0);
    load16(2'h0, n[15:0]);
    pulse(0, n);
    chk1(CNT_OUT[0], 1'b0);
    pulse(0, 1);
    chk1(CNT_OUT[0], 1'b1);
    pulse(0, 3);
    rd16(2'h0, v);
    chk16(v, after(n[15:0], n + 3, 1'b0));
    pulse(0, 2);
    chk1(CNT_OUT[0], 1'b1);
    tict_host_model_i.wr(2'h0, 8'h05);
    pulse(0, 2);
    rd16(2'h0, v);
    chk16(v, after(n[15:0], n + 5, 1'b0));
    tict_host_model_i.wr(2'h0, 8'h00);
    pulse(0, 6);
    chk1(CNT_OUT[0], 1'b1);
    $display("mode 0 test done");
    for (i = 0; i < 4; i = i + 1) begin
      v = i[1] ? 16'h0100 : 16'h0000;
      setw(2'h0, 2'h3, 3'h0, i[0]);
      load16(2'h0, v);
      pulse(0, 4);
      rd16(2'h0, w);
      chk16(w, after(v, 3, i[0]));
    end
    for (i = 1; i < 3; i = i + 1) begin
      r = $urandom;
      setw(2'h1, i[1:0], 3'h0, 1'b0);
      tict_host_model_i.wr(2'h1, r[7:0]);
      pulse(1, 1);
      tict_host_model_i.rd(2'h1, b, oe);
      chk16({8'h00, b}, {8'h00, r[7:0]});
    end
    $display("format and byte order tests done");
    n = 3 + $urandom % 6;
    setw(2'h1, 2'h3, 3'h6, 1'b0);
    chk1(CNT_OUT[1], 1'b1);
    load16(2'h1, n[15:0]);
    pulse(1, 1);
    w = falls[1];
    pulse(1, 3 * n);
    chk16(falls[1] - w, 16'h0003);
    GATE[1] <= 1'b0;
    repeat (4) @(posedge CLK);
    chk1(CNT_OUT[1], 1'b1);
    $display("mode 2 test done");
    for (i = 0; i < 2; i = i + 1) begin
      n = 4 + 2 * ($urandom % 4) + i;
      setw(2'h2, 2'h3, i[0] ? 3'h7 : 3'h3, 1'b0);
      load16(2'h2, n[15:0]);
      pulse(2, 1);
      k = 0;
      repeat (2 * n) begin
        pulse(2, 1);
        k = k + CNT_OUT[2];
      end
      chk16(k[15:0], n + i);
    end
    $display("mode 3 test done");
    n = 2 + $urandom % 8;
    setw(2'h0, 2'h3, 3'h4, 1'b0);
    chk1(CNT_OUT[0], 1'b1);
    load16(2'h0, n[15:0]);
    GATE[0] <= 1'b0;
    w = falls[0];
    pulse(0, n + 3);
    chk16(falls[0] - w, 16'h0000);
    GATE[0] <= 1'b1;
    pulse(0, n + 3);
    chk16(falls[0] - w, 16'h0001);
    chk1(CNT_OUT[0], 1'b1);
    $display("mode 4 test done");
    for (i = 0; i < 2; i = i + 1) begin
      n = 3 + $urandom % 6;
      GATE[1] <= 1'b0;
      setw(2'h1, 2'h3, i[0] ? 3'h5 : 3'h1, 1'b0);
      load16(2'h1, n[15:0]);
      pulse(1, 2);
      w = falls[1];
      GATE[1] <= 1'b1;
      pulse(1, n - 1);
      if (i) begin
        GATE[1] <= 1'b0;
        repeat (HP) @(posedge CLK);
        GATE[1] <= 1'b1;
        pulse(1, n - 1);
        chk16(falls[1] - w, 16'h0000);
      end
      pulse(1, 4);
      chk16(falls[1] - w, 16'h0001);
      chk1(CNT_OUT[1], 1'b1);
    end
    $display("gate trigger tests done");
    w = {13'h0000, CNT_OUT};
    tict_host_model_i.wr(2'h3, 8'hF0);
    tict_host_model_i.rd(2'h3, b, oe);
    chk1(oe, 1'b1);
    chk16({13'h0000, CNT_OUT}, w);
    $display("refusal test done");
    complete_run;
  end
  initial begin : watchdog
    repeat (60000) @(posedge CLK);
    miscompares = miscompares + 1;
    complete_run;
  end
endmodule // tict_timer_test
